// File: rtl/bldcr_defs.vh
// Purpose: constants for the backlight driver config register bank (05h..0Fh)
// Assumes: 8-bit registers reached through the serial register port
// Notes: all offsets, write masks, writable register resets and timing counts live here
// Overview of operation
// - reg 05h bit 7 enables auto frequency adjust, reset cleared.
// - reg 05h bits 5:3 select switch edge slew, typical/slow/fast.
// - reg 06h bits 2:0 hold brightness low three bits, reset all ones.
// - reg 07h holds brightness upper eight bits, reset 0xff.
// - reg 08h bits 7:6 pick dimming sample rate, reset 24 MHz.
// - reg 08h bit 5 picks dimming input active polarity.
// - reg 08h bits 4:2 set duty hysteresis in LSBs, reset four.
// - reg 08h bits 1:0 set dimming glitch filter, reset 200 ns.
// - reg 09h bits 7:4 set sink turn-on ramp, reset 8 ms.
// - reg 09h bits 3:0 set sink turn-off ramp, same coding.
// - reg 0Ah bits 6:4 set duty change ramp; bit 7 reserved.
// - reg 0Ah bits 3:0 set serial brightness change ramp.
// - reg 0Bh upper nibble sets flash timeout in 100 ms steps.
// - reg 0Bh bits 3:0 set flash sink current code, reset 1000.
// - reg 0Ch holds auto frequency upper threshold, reset 0x80.
// - reg 0Dh holds auto frequency lower threshold, reset 0x10.
// - reg 0Eh reports open, short, overcurrent and overtemp faults.
// - reg 0Fh reports overvoltage, undervoltage and flash timeout.
// - mode 00 standby, 01 backlight, 1x flash.
// - register address advances by one after each data byte.
`ifndef BLDCR_DEFS_VH
`define BLDCR_DEFS_VH
`define BLDCR_ADDR_BOOST 8'h05
`define BLDCR_ADDR_BR_LO 8'h06
`define BLDCR_ADDR_BR_HI 8'h07
`define BLDCR_ADDR_DIM 8'h08
`define BLDCR_ADDR_SINK 8'h09
`define BLDCR_ADDR_TRAN 8'h0a
`define BLDCR_ADDR_FLASH 8'h0b
`define BLDCR_ADDR_AF_HI 8'h0c
`define BLDCR_ADDR_AF_LO 8'h0d
`define BLDCR_ADDR_FAULT_FLAGS_ONE 8'h0e
`define BLDCR_ADDR_FAULT_FLAGS_TWO 8'h0f
`define BLDCR_RST_BOOST 8'h00
`define BLDCR_RST_BR_LO 8'h07
`define BLDCR_RST_BR_HI 8'hff
`define BLDCR_RST_DIM 8'h93
`define BLDCR_RST_SINK 8'h44
`define BLDCR_RST_TRAN 8'h00
`define BLDCR_RST_FLASH 8'h58
`define BLDCR_RST_AF_HI 8'h80
`define BLDCR_RST_AF_LO 8'h10
`define BLDCR_MASK_BOOST 8'hf8
`define BLDCR_MASK_BR_LO 8'h07
`define BLDCR_MASK_TRAN 8'h7f
`define BLDCR_MASK_FAULT_FLAGS_TWO 8'he0
`define BLDCR_CLK_HZ 25000000
`define BLDCR_FLASH_STEP_MS 100
`define BLDCR_FLASH_STEP_CYC ((`BLDCR_CLK_HZ / 1000) * `BLDCR_FLASH_STEP_MS)
`define BLDCR_MODE_FLASH_BIT 1
`endif

// File: rtl/bldcr_flag_bit.v
// Purpose: one sticky fault flag, set by hardware, cleared by read or write
// Assumes: clear strobe lasts one cycle
// Notes: a set arriving with a clear wins, so no event is lost
`timescale 1ns/10ps
module bldcr_flag_bit (
    input wire core_clk,
    input wire rst,
    input wire set_evt,
    input wire clr,
    output reg flag
);
    always @(posedge core_clk) begin
        if (rst)
            flag <= 1'b0;
        else if (set_evt)
            flag <= 1'b1;
        else if (clr)
            flag <= 1'b0;
    end
endmodule // bldcr_flag_bit

// File: rtl/bldcr_flash_timer.v
// Purpose: flash timeout timer, counts code x 100 ms while flash is active
// Assumes: core_clk at 25 MHz
// Notes: code zero disables the timeout
`timescale 1ns/10ps
`include "bldcr_defs.vh"
module bldcr_flash_timer #(
    parameter STEP_CYC = `BLDCR_FLASH_STEP_CYC
) (
    input wire core_clk,
    input wire rst,
    input wire flash_active,
    input wire [3:0] strobe_timeout_sel,
    output reg expired
);
    reg [22:0] step_cnt;
    reg [3:0] step_num;
    always @(posedge core_clk) begin
        if (rst || !flash_active || strobe_timeout_sel == 4'h0) begin
            step_cnt <= 23'h0;
            step_num <= 4'h0;
            expired <= 1'b0;
        end else if (!expired) begin
            if (step_cnt == STEP_CYC[22:0] - 23'h1) begin
                step_cnt <= 23'h0;
                step_num <= step_num + 4'h1;
                if (step_num + 4'h1 == strobe_timeout_sel)
                    expired <= 1'b1;
            end else begin
                step_cnt <= step_cnt + 23'h1;
            end
        end
    end
endmodule // bldcr_flash_timer

// File: rtl/bldcr_regs.v
// Purpose: config registers 05h..0Fh of a three-string backlight and flash driver
// Assumes: serial engine gives address load, byte write and byte read strobes
// Notes: fields drive the analog and dimming logic as plain registered outputs
`timescale 1ns/10ps
`include "bldcr_defs.vh"
module bldcr_regs #(
    parameter FLASH_STEP_CYC = `BLDCR_FLASH_STEP_CYC
) (
    input wire core_clk,
    input wire rst,
    input wire addr_load,
    input wire [7:0] addr_in,
    input wire wr_stb,
    input wire [7:0] wr_data,
    input wire rd_stb,
    output reg [7:0] rd_data,
    output reg [7:0] cur_addr,
    input wire [1:0] operating_mode_sel,
    input wire [7:0] fault1_evt,
    input wire [1:0] fault2_evt,
    output reg auto_freq_enable,
    output reg coil_value_select,
    output reg [2:0] edge_slew_select,
    output reg [10:0] brightness_code,
    output reg [1:0] dim_sample_rate,
    output reg dim_polarity,
    output reg [2:0] dim_hysteresis,
    output reg [1:0] dim_glitch_filter,
    output reg [3:0] sink_rise_ramp,
    output reg [3:0] sink_fall_ramp,
    output reg [2:0] duty_change_ramp,
    output reg [3:0] serial_change_ramp,
    output reg [3:0] strobe_timeout_sel,
    output reg [3:0] strobe_current_sel,
    output reg [7:0] auto_freq_upper,
    output reg [7:0] auto_freq_lower,
    output reg standby_mode,
    output reg backlight_mode,
    output reg flash_drive
);
    reg [7:0] boost_control_two;
    reg [7:0] brightness_low_bits;
    reg [7:0] brightness_high_bits;
    reg [7:0] dimming_input_control;
    reg [7:0] sink_ramp_times;
    reg [7:0] brightness_transition_times;
    reg [7:0] flash_settings;
    reg [7:0] auto_freq_upper_threshold;
    reg [7:0] auto_freq_lower_threshold;
    reg [7:0] next_rd_data;
    wire [7:0] fault_flags_one;
    wire [7:0] fault_flags_two;
    wire [10:0] flag_set;
    wire [10:0] flag_q;
    wire clr_fault_flags_one;
    wire clr_fault_flags_two;
    wire flash_req;
    wire timeout_hit;
    wire [7:0] access_addr;
    reg timeout_hit_q;
    wire timeout_evt;

    assign access_addr = cur_addr;
    assign flash_req = operating_mode_sel[`BLDCR_MODE_FLASH_BIT];

    always @(posedge core_clk) begin
        if (rst)
            cur_addr <= 8'h00;
        else if (addr_load)
            cur_addr <= addr_in;
        else if (wr_stb || rd_stb)
            cur_addr <= cur_addr + 8'h01;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            boost_control_two <= `BLDCR_RST_BOOST;
            brightness_low_bits <= `BLDCR_RST_BR_LO;
            brightness_high_bits <= `BLDCR_RST_BR_HI;
            dimming_input_control <= `BLDCR_RST_DIM;
            sink_ramp_times <= `BLDCR_RST_SINK;
            brightness_transition_times <= `BLDCR_RST_TRAN;
            flash_settings <= `BLDCR_RST_FLASH;
            auto_freq_upper_threshold <= `BLDCR_RST_AF_HI;
            auto_freq_lower_threshold <= `BLDCR_RST_AF_LO;
        end else if (wr_stb) begin
            if (access_addr == `BLDCR_ADDR_BOOST)
                boost_control_two <= wr_data & `BLDCR_MASK_BOOST;
            else if (access_addr == `BLDCR_ADDR_BR_LO)
                brightness_low_bits <= wr_data & `BLDCR_MASK_BR_LO;
            else if (access_addr == `BLDCR_ADDR_BR_HI)
                brightness_high_bits <= wr_data;
            else if (access_addr == `BLDCR_ADDR_DIM)
                dimming_input_control <= wr_data;
            else if (access_addr == `BLDCR_ADDR_SINK)
                sink_ramp_times <= wr_data;
            else if (access_addr == `BLDCR_ADDR_TRAN)
                brightness_transition_times <= wr_data & `BLDCR_MASK_TRAN;
            else if (access_addr == `BLDCR_ADDR_FLASH)
                flash_settings <= wr_data;
            else if (access_addr == `BLDCR_ADDR_AF_HI)
                auto_freq_upper_threshold <= wr_data;
            else if (access_addr == `BLDCR_ADDR_AF_LO)
                auto_freq_lower_threshold <= wr_data;
        end
    end

    // flags clear on a read or any write to their register
    assign clr_fault_flags_one = (rd_stb || wr_stb) && access_addr == `BLDCR_ADDR_FAULT_FLAGS_ONE;
    assign clr_fault_flags_two = (rd_stb || wr_stb) && access_addr == `BLDCR_ADDR_FAULT_FLAGS_TWO;
    // expiry edge only; a level would defeat the read clear
    always @(posedge core_clk) begin
        if (rst)
            timeout_hit_q <= 1'b0;
        else
            timeout_hit_q <= timeout_hit;
    end
    assign timeout_evt = timeout_hit && !timeout_hit_q;
    assign flag_set = {timeout_evt, fault2_evt, fault1_evt};

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_flag
            bldcr_flag_bit u_flag (
                .core_clk(core_clk),
                .rst(rst),
                .set_evt(flag_set[gi]),
                .clr(gi < 8 ? clr_fault_flags_one : clr_fault_flags_two),
                .flag(flag_q[gi])
            );
        end
    endgenerate

    assign fault_flags_one = flag_q[7:0];
    // overvoltage, undervoltage, timeout; low bits zero
    assign fault_flags_two = {flag_q[9], flag_q[8], flag_q[10], 5'h00};

    bldcr_flash_timer #(
        .STEP_CYC(FLASH_STEP_CYC)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .flash_active(flash_req),
        .strobe_timeout_sel(flash_settings[7:4]),
        .expired(timeout_hit)
    );

    always @* begin
        if (access_addr == `BLDCR_ADDR_BOOST)
            next_rd_data = boost_control_two;
        else if (access_addr == `BLDCR_ADDR_BR_LO)
            next_rd_data = brightness_low_bits;
        else if (access_addr == `BLDCR_ADDR_BR_HI)
            next_rd_data = brightness_high_bits;
        else if (access_addr == `BLDCR_ADDR_DIM)
            next_rd_data = dimming_input_control;
        else if (access_addr == `BLDCR_ADDR_SINK)
            next_rd_data = sink_ramp_times;
        else if (access_addr == `BLDCR_ADDR_TRAN)
            next_rd_data = brightness_transition_times;
        else if (access_addr == `BLDCR_ADDR_FLASH)
            next_rd_data = flash_settings;
        else if (access_addr == `BLDCR_ADDR_AF_HI)
            next_rd_data = auto_freq_upper_threshold;
        else if (access_addr == `BLDCR_ADDR_AF_LO)
            next_rd_data = auto_freq_lower_threshold;
        else if (access_addr == `BLDCR_ADDR_FAULT_FLAGS_ONE)
            next_rd_data = fault_flags_one;
        else if (access_addr == `BLDCR_ADDR_FAULT_FLAGS_TWO)
            next_rd_data = fault_flags_two;
        else
            next_rd_data = 8'h00;
    end

    // read data tracks the current address so the engine can shift it out
    always @(posedge core_clk) begin
        if (rst)
            rd_data <= 8'h00;
        else
            rd_data <= next_rd_data;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            auto_freq_enable <= 1'b0;
            coil_value_select <= 1'b0;
            edge_slew_select <= 3'h0;
            brightness_code <= 11'h7ff;
            dim_sample_rate <= 2'h2;
            dim_polarity <= 1'b0;
            dim_hysteresis <= 3'h4;
            dim_glitch_filter <= 2'h3;
            sink_rise_ramp <= 4'h4;
            sink_fall_ramp <= 4'h4;
            duty_change_ramp <= 3'h0;
            serial_change_ramp <= 4'h0;
            strobe_timeout_sel <= 4'h5;
            strobe_current_sel <= 4'h8;
            auto_freq_upper <= 8'h80;
            auto_freq_lower <= 8'h10;
            standby_mode <= 1'b1;
            backlight_mode <= 1'b0;
            flash_drive <= 1'b0;
        end else begin
            auto_freq_enable <= boost_control_two[7];
            coil_value_select <= boost_control_two[6];
            edge_slew_select <= boost_control_two[5:3];
            brightness_code <= {brightness_high_bits, brightness_low_bits[2:0]};
            dim_sample_rate <= dimming_input_control[7:6];
            dim_polarity <= dimming_input_control[5];
            dim_hysteresis <= dimming_input_control[4:2];
            dim_glitch_filter <= dimming_input_control[1:0];
            sink_rise_ramp <= sink_ramp_times[7:4];
            sink_fall_ramp <= sink_ramp_times[3:0];
            duty_change_ramp <= brightness_transition_times[6:4];
            serial_change_ramp <= brightness_transition_times[3:0];
            strobe_timeout_sel <= flash_settings[7:4];
            strobe_current_sel <= flash_settings[3:0];
            auto_freq_upper <= auto_freq_upper_threshold;
            auto_freq_lower <= auto_freq_lower_threshold;
            standby_mode <= operating_mode_sel == 2'b00;
            backlight_mode <= operating_mode_sel == 2'b01;
            flash_drive <= flash_req && !timeout_hit;
        end
    end
endmodule // bldcr_regs

// File: testbench/bldcr_host.sv
// Purpose: host side model issuing byte strobes
// Assumes: device advances its own address
// Notes: idle data lines toggle so stale values never look valid
`timescale 1ns/10ps
module bldcr_host (
    input wire core_clk,
    output reg addr_load,
    output reg [7:0] addr_in,
    output reg wr_stb,
    output reg [7:0] wr_data,
    output reg rd_stb
);
    initial begin
        {addr_load, wr_stb, rd_stb} = 3'b000;
        {addr_in, wr_data} = 16'h0;
    end
    task strobe(input [1:0] k, input [7:0] d);
        begin
            @(posedge core_clk);
            addr_load <= (k == 2'd0);
            wr_stb <= (k == 2'd1);
            rd_stb <= (k == 2'd2);
            addr_in <= (k == 2'd3) ? ~addr_in : d;
            wr_data <= (k == 2'd3) ? ~wr_data : d;
        end
    endtask
endmodule // bldcr_host

// File: testbench/bldcr_regs_props.sv
// Purpose: port checks for the config register bank
// Assumes: one strobe per cycle, FLASH_STEP_CYC shortened
// Notes: field outputs lag their register by one cycle
`timescale 1ns/10ps
module bldcr_regs_props #(
    parameter FLASH_STEP_CYC = 10
) (
    input wire core_clk,
    input wire rst,
    input wire addr_load,
    input wire [7:0] addr_in,
    input wire wr_stb,
    input wire [7:0] wr_data,
    input wire rd_stb,
    input wire [7:0] cur_addr,
    input wire [1:0] operating_mode_sel,
    input wire auto_freq_enable,
    input wire [2:0] edge_slew_select,
    input wire [10:0] brightness_code,
    input wire [3:0] strobe_timeout_sel,
    input wire standby_mode,
    input wire backlight_mode,
    input wire flash_drive
);
    reg [7:0] wd1;
    reg [7:0] wd2;
    reg [31:0] fl_cnt;
    // data pipe so a write can be matched to its field two edges later
    always @(posedge core_clk) begin
        wd1 <= wr_data;
        wd2 <= wd1;
        fl_cnt <= (rst || !flash_drive) ? 32'h0 : fl_cnt + 32'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_wr(a);
        wr_stb && !addr_load && cur_addr == a;
    endsequence
    sequence s_hold(m);
        (operating_mode_sel == m) [*2];
    endsequence
    property p_load; addr_load |=> cur_addr == $past(addr_in); endproperty
    property p_wr_inc; wr_stb && !addr_load |=> cur_addr == $past(cur_addr) + 8'h01; endproperty
    property p_rd_inc; rd_stb && !addr_load |=> cur_addr == $past(cur_addr) + 8'h01; endproperty
    property p_bright; s_wr(8'h07) |-> ##2 brightness_code[10:3] == wd2; endproperty
    property p_boost; s_wr(8'h05) |-> ##2 auto_freq_enable == wd2[7] && edge_slew_select == wd2[5:3]; endproperty
    property p_bl; s_hold(2'b01) |-> backlight_mode && !standby_mode && !flash_drive; endproperty
    property p_sb; s_hold(2'b00) |-> standby_mode && !backlight_mode && !flash_drive; endproperty
    property p_enter; $rose(operating_mode_sel[1]) ##1 operating_mode_sel[1] |-> flash_drive; endproperty
    // flash may stand at most code times one step
    property p_tmo; strobe_timeout_sel != 4'h0 |-> fl_cnt <= strobe_timeout_sel * FLASH_STEP_CYC; endproperty
    a_load: assert property (p_load) else $error("address load missed");
    a_wr_inc: assert property (p_wr_inc) else $error("no advance on write");
    a_rd_inc: assert property (p_rd_inc) else $error("no advance on read");
    a_bright: assert property (p_bright) else $error("brightness upper bits wrong");
    a_boost: assert property (p_boost) else $error("boost fields wrong");
    a_bl: assert property (p_bl) else $error("backlight decode wrong");
    a_sb: assert property (p_sb) else $error("standby decode wrong");
    a_enter: assert property (p_enter) else $error("flash not driven");
    a_tmo: assert property (p_tmo) else $error("flash outlived timeout");
endmodule // bldcr_regs_props
bind bldcr_regs bldcr_regs_props #(.FLASH_STEP_CYC(FLASH_STEP_CYC)) i_props (.core_clk, .rst, .addr_load,
    .addr_in, .wr_stb, .wr_data, .rd_stb, .cur_addr, .operating_mode_sel, .auto_freq_enable,
    .edge_slew_select, .brightness_code, .strobe_timeout_sel, .standby_mode, .backlight_mode, .flash_drive);

// File: testbench/tb.sv
// Purpose: register bank bench
// Assumes: FLASH_STEP_CYC of 10
// Notes: reads go through the device's own address advance
`timescale 1ns/10ps
module tb;
    reg core_clk, rst;
    reg [1:0] operating_mode_sel, fault2_evt;
    reg [7:0] fault1_evt;
    wire addr_load, wr_stb, rd_stb, auto_freq_enable, coil_value_select, dim_polarity;
    wire standby_mode, backlight_mode, flash_drive;
    wire [7:0] addr_in, wr_data, rd_data, cur_addr, auto_freq_upper, auto_freq_lower;
    wire [10:0] brightness_code;
    wire [2:0] edge_slew_select, dim_hysteresis, duty_change_ramp;
    wire [1:0] dim_sample_rate, dim_glitch_filter;
    wire [3:0] sink_rise_ramp, sink_fall_ramp, serial_change_ramp, strobe_timeout_sel, strobe_current_sel;
    integer failures, samples_checked, cyc, i, m;
    reg [7:0] exp_v [0:10];
    reg [7:0] mask [0:10];
    bldcr_host i_host (.core_clk, .addr_load, .addr_in, .wr_stb, .wr_data, .rd_stb);
    bldcr_regs #(.FLASH_STEP_CYC(10)) i_dut (.core_clk, .rst, .addr_load, .addr_in, .wr_stb, .wr_data,
        .rd_stb, .rd_data, .cur_addr, .operating_mode_sel, .fault1_evt, .fault2_evt, .auto_freq_enable,
        .coil_value_select, .edge_slew_select, .brightness_code, .dim_sample_rate, .dim_polarity,
        .dim_hysteresis, .dim_glitch_filter, .sink_rise_ramp, .sink_fall_ramp, .duty_change_ramp,
        .serial_change_ramp, .strobe_timeout_sel, .strobe_current_sel, .auto_freq_upper,
        .auto_freq_lower, .standby_mode, .backlight_mode, .flash_drive);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task check(input [63:0] what, input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("counts: %0d checked, %0d failed", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task idle(input integer n);
        repeat (n) i_host.strobe(2'd3, 8'h00);
    endtask
    task rd_burst(input [7:0] a, input integer n);
        integer k;
        begin
            i_host.strobe(2'd0, a);
            idle(2);
            for (k = 0; k < n; k = k + 1) begin
                #1 check("rd_data", rd_data, exp_v[k]);
                i_host.strobe(2'd2, 8'h00);
                idle(2);
            end
        end
    endtask
    task wr_burst(input [7:0] a, input integer n, input [7:0] d);
        integer k;
        begin
            i_host.strobe(2'd0, a);
            for (k = 0; k < n; k = k + 1) i_host.strobe(2'd1, d);
            idle(2);
        end
    endtask
    task fill(input [7:0] d);
        for (i = 0; i < 11; i = i + 1) exp_v[i] = d & mask[i];
    endtask
    initial begin
        cyc = 0;
        forever @(posedge core_clk) begin
            cyc = cyc + 1;
            if (cyc == 3000) begin
                failures = failures + 1;
                report_and_stop;
            end
        end
    end
    initial begin
        {failures, samples_checked} = 0;
        {rst, operating_mode_sel, fault1_evt, fault2_evt} = {1'b1, 12'h0};
        {mask[0], mask[1], mask[2], mask[3], mask[4], mask[5]} = 48'hf807ffffff7f;
        {mask[6], mask[7], mask[8], mask[9], mask[10]} = 40'hffffff0000;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        {exp_v[0], exp_v[1], exp_v[2], exp_v[3], exp_v[4], exp_v[5]} = 48'h0007ff934400;
        {exp_v[6], exp_v[7], exp_v[8], exp_v[9], exp_v[10]} = 40'h5880100000;
        rd_burst(8'h05, 11);
        $display("test reset_values done");
        wr_burst(8'h05, 11, 8'hff);
        #1 check("bright", brightness_code, 11'h7ff);
        check("dim", {dim_sample_rate, dim_polarity, dim_hysteresis, dim_glitch_filter}, 8'hff);
        check("ramps", {sink_rise_ramp, sink_fall_ramp, duty_change_ramp, serial_change_ramp}, 15'h7fff);
        check("flash", {strobe_timeout_sel, strobe_current_sel}, 8'hff);
        check("autof", {auto_freq_upper, auto_freq_lower, coil_value_select}, 17'h1ffff);
        check("boost", {auto_freq_enable, edge_slew_select}, 4'hf);
        check("cur_addr", cur_addr, 8'h10);
        fill(8'hff);
        rd_burst(8'h05, 11);
        wr_burst(8'h05, 11, 8'h00);
        #1 check("bright0", brightness_code, 11'h000);
        fill(8'h00);
        rd_burst(8'h05, 11);
        $display("test write_readback done");
        @(posedge core_clk) {fault1_evt, fault2_evt} <= 10'h297;
        @(posedge core_clk) {fault1_evt, fault2_evt} <= 10'h000;
        {exp_v[0], exp_v[1]} = 16'ha5c0;
        rd_burst(8'h0e, 2);
        {exp_v[0], exp_v[1]} = 16'h0000;
        rd_burst(8'h0e, 2);
        $display("test fault_flags done");
        wr_burst(8'h0b, 1, 8'h08);
        for (m = 0; m < 4; m = m + 1) begin
            @(posedge core_clk) operating_mode_sel <= m[1:0];
            repeat (3) @(posedge core_clk);
            #1 check("mode", {standby_mode, backlight_mode, flash_drive}, (m == 0) ? 4 : (m == 1) ? 2 : 1);
        end
        repeat (40) @(posedge core_clk);
        #1 check("notmo", flash_drive, 1'b1);
        @(posedge core_clk) operating_mode_sel <= 2'b00;
        wr_burst(8'h0b, 1, 8'h18);
        @(posedge core_clk) operating_mode_sel <= 2'b10;
        repeat (5) @(posedge core_clk);
        #1 check("fl_on", flash_drive, 1'b1);
        repeat (30) @(posedge core_clk);
        #1 check("fl_off", flash_drive, 1'b0);
        exp_v[1] = 8'h20;
        rd_burst(8'h0e, 2);
        exp_v[1] = 8'h00;
        rd_burst(8'h0e, 2);
        #1 check("fl_held", flash_drive, 1'b0);
        @(posedge core_clk) operating_mode_sel <= 2'b00;
        $display("test flash_timeout done");
        report_and_stop;
    end
endmodule // tb
